/* logic/pba_pkg.sv */
package pba_pkg;
	// register indices on the plain register port
	localparam logic [1:0] ADDR_PRIO_ONE = 2'h0;
	localparam logic [1:0] ADDR_PRIO_EXT = 2'h1;
	localparam logic [1:0] ADDR_SLOT_SEL = 2'h2;
	localparam logic [1:0] ADDR_GEN_CTL = 2'h3;
	// reset values
	localparam logic [7:0] RST_PRIO_ONE = 8'h00e0;
	localparam logic [7:0] RST_PRIO_EXT = 8'h0001;
	localparam logic [7:0] RST_SLOT_SEL = 8'h0000;
	localparam logic [7:0] RST_GEN_CTL = 8'h0080;
	// field positions
	localparam int ROT_EN_LO = 5;
	localparam int FPMOD_LO = 3;
	localparam int PFIX_LO = 0;
	localparam int HOLD_BIT = 4;
	localparam int L2ROT_BIT = 0;
	localparam int GAT_BIT = 7;
	localparam int ATO_LO = 3;
	localparam int ATO_EN_BIT = 2;
	localparam int PARK_BIT = 1;
	localparam int LOCK_BIT = 0;
	// timeout limits in clocks
	localparam logic [5:0] ATO_16 = 6'h10;
	localparam logic [5:0] ATO_4 = 6'h04;
	localparam logic [5:0] ATO_8 = 6'h08;
	localparam logic [5:0] ATO_32 = 6'h20;
	// requester numbering
	localparam int NREQ = 7;
	localparam logic [2:0] M_IDE = 3'h0;
	localparam logic [2:0] M_ISA = 3'h1;
	localparam logic [2:0] M_EXT0 = 3'h2;
	localparam logic [2:0] M_EXT1 = 3'h3;
	localparam logic [2:0] M_EXT2 = 3'h4;
	localparam logic [2:0] M_HOST = 3'h5;
	localparam logic [2:0] M_EXT3 = 3'h6;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_BUSY = 2'b10
	} pba_state_type;
	typedef struct packed {
		logic [7:0] prio_one;
		logic [7:0] prio_ext;
		logic [7:0] slot_sel;
		logic [7:0] gen_ctl;
	} pba_regs_type;
endpackage : pba_pkg

/* logic/pba_arbiter.sv */
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pba_arbiter #(
	parameter int NUM_REQ = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// pci request pins, frame, lock and flush strap
	input wire logic ide_master_request_n,
	input wire logic isa_bridge_request_n,
	input wire logic host_request_n,
	input wire logic ext_master0_request_n,
	input wire logic ext_master1_request_n,
	input wire logic ext_master2_request_n,
	input wire logic ext_master3_request_n,
	input wire logic frame_n,
	input wire logic lock_n,
	input wire logic flush_strap_n,
	// grants and status
	output logic [6:0] grant_n,
	output logic host_grant_n,
	output logic bus_locked,
	output logic flush_enable,
	output logic grant_frame_timeout
);
	// bank wiring below is written for exactly seven requesters
	if (NUM_REQ != pba_pkg::NREQ) begin : g_bad_num_req
		$error("pba_arbiter serves exactly seven requesters");
	end

	pba_pkg::pba_regs_type regs_q;
	pba_pkg::pba_state_type state_q;
	logic [6:0] req_s1_q, req_q;
	logic [2:0] misc_s1_q, misc_q;
	logic frame_q, lock_q, strap_q;
	logic [2:0] owner_q, owner_d;
	logic [2:0] bank_rot_q;
	logic [2:0] slot_q;
	logic [5:0] ato_cnt_q;
	logic [5:0] ato_lim;
	logic [1:0] settle_q;
	logic strap_low_q;
	logic any_req, win_valid, timeout_hit;
	logic bank1_winner, bank2_winner, bank3_winner;
	logic [3:0] bank_req;
	logic [1:0] scheme, win_bank;
	logic [2:0] bank_pick [4];
	logic [2:0] pfix_eff, rot_en;

	// two-stage sync of all pin inputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			req_s1_q <= 7'h0000;
			req_q <= 7'h0000;
			misc_s1_q <= 3'h0000;
			misc_q <= 3'h0000;
		end else begin
			req_s1_q <= ~{ext_master3_request_n, host_request_n,
				ext_master2_request_n, ext_master1_request_n,
				ext_master0_request_n, isa_bridge_request_n,
				ide_master_request_n};
			req_q <= req_s1_q;
			misc_s1_q <= ~{frame_n, lock_n, flush_strap_n};
			misc_q <= misc_s1_q;
		end
	end
	assign frame_q = misc_q[2];
	assign lock_q = misc_q[1];
	assign strap_q = misc_q[0];

	// register writes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			regs_q.prio_one <= pba_pkg::RST_PRIO_ONE;
			regs_q.prio_ext <= pba_pkg::RST_PRIO_EXT;
			regs_q.slot_sel <= pba_pkg::RST_SLOT_SEL;
			regs_q.gen_ctl <= pba_pkg::RST_GEN_CTL;
		end else if (reg_wr) begin
			unique case (reg_addr)
				pba_pkg::ADDR_PRIO_ONE: regs_q.prio_one <= reg_wdata;
				pba_pkg::ADDR_PRIO_EXT: regs_q.prio_ext <= reg_wdata;
				pba_pkg::ADDR_SLOT_SEL: regs_q.slot_sel <= reg_wdata;
				pba_pkg::ADDR_GEN_CTL: regs_q.gen_ctl <= reg_wdata;
			endcase
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 8'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				pba_pkg::ADDR_PRIO_ONE: reg_rdata <= regs_q.prio_one;
				pba_pkg::ADDR_PRIO_EXT: reg_rdata <= regs_q.prio_ext;
				pba_pkg::ADDR_SLOT_SEL: reg_rdata <= regs_q.slot_sel;
				pba_pkg::ADDR_GEN_CTL: reg_rdata <= regs_q.gen_ctl;
			endcase
		end else begin
			reg_rdata <= 8'h0000;
		end
	end

	// strap read only once the sync chain holds real pin values;
	// the flops still carry their reset zeros for two edges
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			settle_q <= 2'b00;
		end else if (!settle_q[1]) begin
			settle_q <= settle_q + 2'b01;
		end
	end

	// a strap seen low after reset sticks until the next reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			strap_low_q <= 1'b0;
			flush_enable <= 1'b0;
		end else begin
			strap_low_q <= strap_low_q | (settle_q[1] & strap_q);
			flush_enable <= settle_q[1] & ~strap_low_q & ~strap_q &
				regs_q.gen_ctl[pba_pkg::GAT_BIT];
		end
	end

	// level-1 banks: bank 0 is ide alone, its controls tied to zero
	assign pfix_eff = regs_q.prio_one[pba_pkg::PFIX_LO +: 3];
	assign rot_en = regs_q.prio_one[pba_pkg::ROT_EN_LO +: 3];
	assign bank_pick[0] = pba_pkg::M_IDE;

	// bank 1: isa bridge over external master 0
	pba_pair_pick #(
		.UP_ID(pba_pkg::M_ISA),
		.LO_ID(pba_pkg::M_EXT0)
	) pba_pair_pick_bank1_i (
		.up_req(req_q[pba_pkg::M_ISA]),
		.lo_req(req_q[pba_pkg::M_EXT0]),
		.lo_first(pfix_eff[0] ^ bank_rot_q[0]),
		.pick(bank_pick[1])
	);

	// bank 2: external master 1 over external master 2
	pba_pair_pick #(
		.UP_ID(pba_pkg::M_EXT1),
		.LO_ID(pba_pkg::M_EXT2)
	) pba_pair_pick_bank2_i (
		.up_req(req_q[pba_pkg::M_EXT1]),
		.lo_req(req_q[pba_pkg::M_EXT2]),
		.lo_first(pfix_eff[1] ^ bank_rot_q[1]),
		.pick(bank_pick[2])
	);

	// bank 3: host over external master 3
	pba_pair_pick #(
		.UP_ID(pba_pkg::M_HOST),
		.LO_ID(pba_pkg::M_EXT3)
	) pba_pair_pick_bank3_i (
		.up_req(req_q[pba_pkg::M_HOST]),
		.lo_req(req_q[pba_pkg::M_EXT3]),
		.lo_first(pfix_eff[2] ^ bank_rot_q[2]),
		.pick(bank_pick[3])
	);
	assign bank1_winner = req_q[pba_pkg::M_ISA] | req_q[pba_pkg::M_EXT0];
	assign bank2_winner = req_q[pba_pkg::M_EXT1] | req_q[pba_pkg::M_EXT2];
	assign bank3_winner = req_q[pba_pkg::M_HOST] | req_q[pba_pkg::M_EXT3];
	assign bank_req = {bank3_winner, bank2_winner, bank1_winner,
		req_q[pba_pkg::M_IDE]};

	// level-2 scheme: fixed code, or eight-slot round robin
	always_comb begin
		if (!regs_q.prio_ext[pba_pkg::L2ROT_BIT])
			scheme = regs_q.prio_one[pba_pkg::FPMOD_LO +: 2];
		else if (!slot_q[2])
			scheme = slot_q[1:0];
		else
			scheme = regs_q.slot_sel[2 * slot_q[1:0] +: 2];
	end

	// scheme n starts at bank n and wraps upward
	always_comb begin
		win_bank = scheme;
		win_valid = 1'b0;
		for (int i = 3; i >= 0; i--) begin
			if (bank_req[2'(scheme + 2'(i))]) begin
				win_bank = 2'(scheme + 2'(i));
				win_valid = 1'b1;
			end
		end
	end
	assign any_req = win_valid;

	// timeout limit and expiry
	always_comb begin
		unique case (regs_q.gen_ctl[pba_pkg::ATO_LO +: 2])
			2'b00: ato_lim = pba_pkg::ATO_16;
			2'b01: ato_lim = pba_pkg::ATO_4;
			2'b10: ato_lim = pba_pkg::ATO_8;
			2'b11: ato_lim = pba_pkg::ATO_32;
		endcase
	end
	assign timeout_hit = regs_q.gen_ctl[pba_pkg::ATO_EN_BIT] &&
		state_q == pba_pkg::ST_WAIT && ato_cnt_q >= ato_lim;

	// next owner; bus stays with a locked or active owner
	always_comb begin
		owner_d = owner_q;
		if (timeout_hit || state_q != pba_pkg::ST_BUSY) begin
			if (any_req &&
				!(timeout_hit && bank_pick[win_bank] == owner_q))
				owner_d = bank_pick[win_bank];
			else if (!regs_q.gen_ctl[pba_pkg::PARK_BIT])
				owner_d = pba_pkg::M_HOST;
		end
		if (owner_q == pba_pkg::M_HOST && req_q[pba_pkg::M_HOST] &&
			regs_q.prio_ext[pba_pkg::HOLD_BIT])
			owner_d = pba_pkg::M_HOST;
		else if (owner_q == pba_pkg::M_HOST && state_q == pba_pkg::ST_WAIT &&
			(req_q & ~(7'h0001 << pba_pkg::M_HOST)) != 7'h0000 && any_req)
			owner_d = bank_pick[win_bank];
		if (bus_locked)
			owner_d = owner_q;
	end

	// grant state; busy from frame until bus goes idle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= pba_pkg::ST_IDLE;
			owner_q <= pba_pkg::M_HOST;
			ato_cnt_q <= 6'h0000;
			grant_frame_timeout <= 1'b0;
		end else begin
			owner_q <= owner_d;
			grant_frame_timeout <= timeout_hit;
			unique case (state_q)
				pba_pkg::ST_IDLE: begin
					ato_cnt_q <= 6'h0000;
					if (any_req)
						state_q <= pba_pkg::ST_WAIT;
				end
				pba_pkg::ST_WAIT: begin
					ato_cnt_q <= ato_cnt_q + 6'h0001;
					if (frame_q)
						state_q <= pba_pkg::ST_BUSY;
					else if (timeout_hit || owner_d != owner_q)
						ato_cnt_q <= 6'h0000;
					else if (!req_q[owner_q])
						state_q <= pba_pkg::ST_IDLE;
				end
				pba_pkg::ST_BUSY: begin
					ato_cnt_q <= 6'h0000;
					if (!frame_q && !bus_locked)
						state_q <= any_req ? pba_pkg::ST_WAIT
							: pba_pkg::ST_IDLE;
				end
				default: state_q <= pba_pkg::ST_IDLE;
			endcase
		end
	end

	// lock follows frame start while enabled
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bus_locked <= 1'b0;
		end else if (!regs_q.gen_ctl[pba_pkg::LOCK_BIT]) begin
			bus_locked <= 1'b0;
		end else if (state_q == pba_pkg::ST_BUSY && lock_q) begin
			bus_locked <= 1'b1;
		end else if (!lock_q && !frame_q) begin
			bus_locked <= 1'b0;
		end
	end

	// rotation: bank priority toggles when its winner starts a frame
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bank_rot_q <= 3'h0000;
			slot_q <= 3'h0000;
		end else if (state_q == pba_pkg::ST_WAIT && frame_q) begin
			slot_q <= slot_q + 3'h0001;
			for (int b = 1; b <= 3; b++) begin
				if (rot_en[b - 1] && bank_pick[b] == owner_q &&
					bank_req[b])
					bank_rot_q[b - 1] <= ~bank_rot_q[b - 1];
				else if (!rot_en[b - 1])
					bank_rot_q[b - 1] <= 1'b0;
			end
		end
	end

	// grants from flops, one active at a time
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			grant_n <= 7'h007f;
			host_grant_n <= 1'b1;
		end else begin
			grant_n <= ~(7'h0001 << owner_d);
			host_grant_n <= owner_d != pba_pkg::M_HOST;
		end
	end
endmodule : pba_arbiter

// one level-1 pair; lo_first hands priority to the lower-listed line
module pba_pair_pick #(
	parameter logic [2:0] UP_ID = pba_pkg::M_ISA,
	parameter logic [2:0] LO_ID = pba_pkg::M_EXT0
) (
	// requests of the pair
	input wire logic up_req,
	input wire logic lo_req,
	// priority control
	input wire logic lo_first,
	// chosen requester
	output logic [2:0] pick
);
	// with neither line asking the pick is ignored upstream
	always_comb begin
		if (lo_first ? (lo_req || !up_req) : !up_req)
			pick = LO_ID;
		else
			pick = UP_ID;
	end
endmodule : pba_pair_pick
`default_nettype wire

/* verif/pba_arbiter_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pba_arbiter_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// pci side
	input wire logic ide_master_request_n,
	input wire logic frame_n,
	input wire logic [6:0] grant_n,
	input wire logic host_grant_n,
	input wire logic grant_frame_timeout
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	one_grant_a: assert property ($onehot0(~grant_n))
		else $error("two grants");
	host_copy_a: assert property (host_grant_n == grant_n[5])
		else $error("host grant split");
	reset_idle_a: assert property (disable iff (1'b0)
		!rst_b |=> grant_n == 7'h7f) else $error("grant in reset");
	park_host_a: assert property ($rose(rst_b) |=> !host_grant_n)
		else $error("no park on host");
	// two sync flops plus the grant flop
	ide_asked_a: assert property ($fell(grant_n[0])
		|-> !$past(ide_master_request_n, 3)) else $error("ide grant unasked");
	pulse_once_a: assert property (grant_frame_timeout
		|=> !grant_frame_timeout) else $error("long timeout pulse");
	frame_idle_a: assert property (grant_frame_timeout
		|-> $past(frame_n) && $past(frame_n, 2)) else $error("timeout in frame");
	readback_a: assert property ($past(reg_wr) && reg_rd
		&& reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("read after write");
	cover property (grant_frame_timeout);
	cover property ($fell(grant_n[0]));
	cover property ($past(reg_wr) && reg_rd);
endmodule : pba_arbiter_props
bind pba_arbiter pba_arbiter_props pba_arbiter_props_i (.*);
`default_nettype wire

/* verif/pba_masters.sv */
`timescale 1ns/1ps
`default_nettype none
module pba_masters (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// bench control: new requests, refuse to start frames
	input wire logic [6:0] want,
	input wire logic mute,
	// bus side
	input wire logic [6:0] grant_n,
	output logic [6:0] req_n,
	output logic frame_n
);
	logic [1:0] len_q;
	logic [6:0] won;
	assign won = ~grant_n & ~req_n;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			req_n <= 7'h7f;
			frame_n <= 1'b1;
			len_q <= 2'h0;
		end else if (!frame_n) begin
			len_q <= len_q - 2'h1;
			frame_n <= len_q == 2'h0;
		end else if (won != 7'h00 && !mute) begin
			// request dropped with frame so one grant serves one transfer
			frame_n <= 1'b0;
			req_n <= req_n | won;
			len_q <= 2'h2;
		end else begin
			req_n <= req_n & ~want;
		end
	end
endmodule : pba_masters
`default_nettype wire

/* verif/pba_arbiter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pba_arbiter_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [6:0] want = 7'h00;
	logic mute = 1'b0;
	logic [7:0] reg_rdata;
	logic [6:0] req_n;
	logic [6:0] grant_n;
	logic frame_n;
	logic flush_en;
	logic tmo;
	logic [31:0] seed = 32'h92f6_c34c;
	int lims[4] = '{16, 4, 8, 32};
	int error_cnt = 0;
	int checked = 0;
	int n;
	always #20 clk = ~clk;
	pba_arbiter pba_arbiter_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ide_master_request_n(req_n[0]),
		.isa_bridge_request_n(req_n[1]), .host_request_n(req_n[5]),
		.ext_master0_request_n(req_n[2]), .ext_master1_request_n(req_n[3]),
		.ext_master2_request_n(req_n[4]), .ext_master3_request_n(req_n[6]),
		.frame_n(frame_n), .lock_n(1'b1), .flush_strap_n(1'b1),
		.grant_n(grant_n), .host_grant_n(), .bus_locked(),
		.flush_enable(flush_en), .grant_frame_timeout(tmo));
	pba_masters pba_masters_i (.clk(clk), .rst_b(rst_b), .want(want),
		.mute(mute), .grant_n(grant_n), .req_n(req_n), .frame_n(frame_n));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// first winner with ide and banks 1..3 asking, host silent
	function automatic logic [6:0] head(input logic [1:0] c,
		input logic [2:0] pf);
		case (c)
			2'h0: return 7'h01;
			2'h1: return pf[0] ? 7'h04 : 7'h02;
			2'h2: return pf[1] ? 7'h10 : 7'h08;
			default: return 7'h40;
		endcase
	endfunction : head
	task automatic cmp(input string what, input logic [7:0] e,
		input logic [7:0] s);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask : cmp
	task automatic bus(input logic w, input logic r, input logic [1:0] a,
		input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		#1 cmp("register", e, reg_rdata);
	endtask : rd
	task automatic drain(input logic [6:0] pk);
		n = 0;
		while ((req_n !== 7'h7f || !frame_n || grant_n !== ~pk) && n < 400) begin
			@(negedge clk);
			n++;
		end
		cmp("park", {1'b0, ~pk}, {1'b0, grant_n});
		@(posedge clk);
	endtask : drain
	task automatic race(input logic [7:0] p, input logic [6:0] w,
		input logic [6:0] e, input logic [6:0] pk);
		bus(1'b1, 1'b0, pba_pkg::ADDR_PRIO_ONE, p);
		want <= w;
		bus(1'b0, 1'b0, 2'h0, 8'h00);
		want <= 7'h00;
		repeat (4) @(posedge clk);
		#1 cmp("grant", {1'b0, ~e}, {1'b0, grant_n});
		drain(pk);
	endtask : race
	// muted master never frames, so the grant times out whenever ATO_EN_BIT is set in g
	task automatic tmo_run(input logic [7:0] g, output int m);
		bus(1'b1, 1'b0, pba_pkg::ADDR_GEN_CTL, g);
		mute <= 1'b1;
		want <= 7'h08;
		bus(1'b0, 1'b0, 2'h0, 8'h00);
		want <= 7'h00;
		m = 0;
		while (grant_n[3] !== 1'b0 && m < 20) begin
			@(negedge clk);
			m++;
		end
		m = 0;
		while (tmo !== 1'b1 && m < 60) begin
			@(negedge clk);
			m++;
		end
		mute <= 1'b0;
		drain(7'h20);
	endtask : tmo_run
	task automatic summarize();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		rd(pba_pkg::ADDR_PRIO_ONE, 8'he0);
		rd(pba_pkg::ADDR_PRIO_EXT, 8'h01);
		rd(pba_pkg::ADDR_SLOT_SEL, 8'h00);
		rd(pba_pkg::ADDR_GEN_CTL, 8'h80);
		cmp("flush", 8'h01, {7'h00, flush_en});
		cmp("park", 8'h5f, {1'b0, grant_n});
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			bus(1'b1, 1'b0, seed[1:0], seed[15:8]);
			rd(seed[1:0], seed[15:8]);
		end
		bus(1'b1, 1'b0, pba_pkg::ADDR_GEN_CTL, 8'h00);
		bus(1'b0, 1'b0, 2'h0, 8'h00);
		#1 cmp("flush", 8'h00, {7'h00, flush_en});
		bus(1'b1, 1'b0, pba_pkg::ADDR_PRIO_EXT, 8'h00);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			race({3'h0, i[1:0], seed[2:0]}, 7'h5f,
				head(i[1:0], seed[2:0]), 7'h20);
		end
		bus(1'b1, 1'b0, pba_pkg::ADDR_GEN_CTL, 8'h02);
		race(8'h00, 7'h10, 7'h10, 7'h10);
		bus(1'b1, 1'b0, pba_pkg::ADDR_GEN_CTL, 8'h00);
		race(8'h00, 7'h10, 7'h10, 7'h20);
		for (int c = 0; c < 4; c++) begin
			tmo_run({3'h0, c[1:0], 3'h4}, n);
			cmp("timeout", 8'h01,
				{7'h00, n >= lims[c] - 1 && n <= lims[c] + 2});
		end
		tmo_run(8'h18, n);
		cmp("timeout off", 8'h3c, n[7:0]);
		summarize();
	end
	initial begin
		#400000;
		error_cnt++;
		summarize();
	end
endmodule : pba_arbiter_tb
`default_nettype wire
